// >>> common/loop_test_pkg.sv
// constants shared by the loop-test unit and its helpers
// assumes a 100 MHz system clock and a 32-bit APB register port
package loop_test_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0c;
    localparam logic [7:0] OFS_RANGE = 8'h10;
    // command bits
    localparam int CMD_START_BIT = 0;
    localparam int CMD_CLEAR_BIT = 1;
    // status bits
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_PHASE_BIT = 2;
    localparam int STAT_GEN_BIT = 3;
    // second control word fields; first word is the interrogation time
    localparam int TYPE_LSB = 0;
    localparam int TYPE_W = 4;
    localparam int CHAN_LSB = 4;
    localparam int CHAN_W = 2;
    localparam int MODE_BIT = 6;
    localparam logic [1:0] CHAN_SUM = 2'h0;
    localparam logic [1:0] CHAN_DIFF = 2'h1;
    localparam logic [1:0] CHAN_OMNI = 2'h2;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // result words
    localparam int RESULT_WORDS = 11;
    localparam logic [3:0] RES_TOA = 4'h0;
    localparam logic [3:0] RES_AMP = 4'h1;
    localparam logic [3:0] RES_FLAGS = 4'h2;
    localparam logic [3:0] RES_DATA0 = 4'h3;
    localparam logic [3:0] RES_DATA3 = 4'h6;
    localparam logic [3:0] RES_CTRL1 = 4'h7;
    localparam logic [3:0] RES_CTRL2 = 4'h8;
    localparam logic [3:0] RES_COUNT = 4'h9;
    localparam logic [3:0] RES_END = 4'ha;
    localparam int FLAG_SIDE_BIT = 0;
    localparam int FLAG_ERR_BIT = 1;
    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int RANGE_HZ = 16_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int CHIP_NS = 500;
    localparam int CHIP_CYCLES = (CHIP_NS * CLK_MHZ + 999) / 1000;
    localparam int ATCRBS_BITS = 14;
    localparam int DABS_BITS = 56;
endpackage

// >>> src/pin_sync.sv
// two-stage synchroniser for a group of asynchronous pin levels
// assumes each bit is an independent level, not a bus word
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= '0;
            pin_out <= '0;
        end else begin
            meta_q <= pin_in;
            pin_out <= meta_q;
        end
    end
endmodule

// >>> src/loop_test_unit.sv
// loop-test unit: test interrogation injector and single-reply sampler
// assumes APB master on clk_sys; IF video, ADC and sync pins asynchronous
//
// Overview of operation
// - control words written in pairs, odd first
// - half pair never replaces settings in force
// - type picks pattern; zero disables generator
// - fire when range clock equals programmed time
// - interrogation never touches busy, done, interrupt
// - full reply clears busy, sets done, interrupts
// - on detection sample amplitude and data
// - eleven result words after each capture
// - boresight side valid only near balance
// - malformed DABS PPM sets error bit
// - results read in fixed order, any count
// - start resets sampler, uses held words
// - generator and sampler may run together
// - sampling begins on first leading edge
// - one reply per capture only
// - ATCRBS interrogation zeroes the range clock
// - at interrupt busy is zero, done one
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module loop_test_unit #(
    parameter int ADC_W = 10,
    parameter int CHIP_CYCLES = loop_test_pkg::CHIP_CYCLES,
    parameter int ATCRBS_BITS = loop_test_pkg::ATCRBS_BITS,
    parameter int DABS_BITS = loop_test_pkg::DABS_BITS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // if video levels: sum, difference, omni
    input wire logic [2:0] if_pulse,
    input wire logic boresight_left,
    input wire logic atcrbs_interrog,
    // a/d converter
    output logic adc_start,
    output logic [1:0] adc_chan,
    input wire logic adc_done,
    input wire logic [ADC_W-1:0] adc_data,
    // interrogation injector
    output logic interrog_fire,
    output logic [3:0] interrog_type,
    // host handshake
    output logic busy,
    output logic done,
    output logic irq_req
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_SAMPLE = 2'b10,
        ST_FINISH = 2'b11
    } reply_state_e;

    localparam int CHIP_CW = $clog2(CHIP_CYCLES + 1);
    localparam logic [CHIP_CW-1:0] CHIP_LAST = CHIP_CW'(CHIP_CYCLES - 1);
    localparam logic [CHIP_CW-1:0] CHIP_MID = CHIP_CW'(CHIP_CYCLES / 2);
    localparam logic [7:0] CHIPS_A = 8'(ATCRBS_BITS);
    localparam logic [7:0] CHIPS_D = 8'(2 * DABS_BITS);
    localparam logic [7:0] RANGE_STEP = 8'(loop_test_pkg::RANGE_HZ / 1_000_000);
    localparam logic [7:0] RANGE_MOD = 8'(loop_test_pkg::CLK_MHZ);

    // synchronised pins
    logic [5:0] pins_s;
    logic [2:0] video_s;
    logic left_s, atcrbs_s, adc_done_s;
    logic atcrbs_prev_q, adc_prev_q, video_prev_q;

    pin_sync #(.WIDTH(6)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in({adc_done, atcrbs_interrog, boresight_left, if_pulse}),
        .pin_out(pins_s)
    );
    assign video_s = pins_s[2:0];
    assign left_s = pins_s[3];
    assign atcrbs_s = pins_s[4];
    assign adc_done_s = pins_s[5];

    // apb decode
    logic wr_acc, rd_acc, setup;
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign pready = 1'b1;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == loop_test_pkg::OFS_CTRL) ||
                 (a == loop_test_pkg::OFS_CMD) ||
                 (a == loop_test_pkg::OFS_STATUS) ||
                 (a == loop_test_pkg::OFS_RESULT) ||
                 (a == loop_test_pkg::OFS_RANGE);
    endfunction

    logic cmd_wr, start, clear_io, ctrl_wr, result_rd;
    assign cmd_wr = wr_acc && (paddr == loop_test_pkg::OFS_CMD);
    assign start = cmd_wr && pwdata[loop_test_pkg::CMD_START_BIT];
    assign clear_io = cmd_wr && pwdata[loop_test_pkg::CMD_CLEAR_BIT];
    assign ctrl_wr = wr_acc && (paddr == loop_test_pkg::OFS_CTRL);
    assign result_rd = rd_acc && (paddr == loop_test_pkg::OFS_RESULT);

    // control word pair
    logic phase_q, gen_en_q;
    logic [15:0] pend1_q, word1_q, word2_q;
    logic pair_done;
    assign pair_done = ctrl_wr && phase_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_q <= 1'b0;
            pend1_q <= loop_test_pkg::CTRL_RESET;
            word1_q <= loop_test_pkg::CTRL_RESET;
            word2_q <= loop_test_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            phase_q <= !phase_q;
            if (!phase_q) begin
                pend1_q <= pwdata[15:0];
            end else begin
                word1_q <= pend1_q;
                word2_q <= pwdata[15:0];
            end
        end
    end

    logic [3:0] itype;
    logic [1:0] chan;
    logic dabs_mode;
    assign itype = word2_q[loop_test_pkg::TYPE_LSB +: loop_test_pkg::TYPE_W];
    assign chan = word2_q[loop_test_pkg::CHAN_LSB +: loop_test_pkg::CHAN_W];
    assign dabs_mode = word2_q[loop_test_pkg::MODE_BIT];

    // generator enable: a new pair or start enables, clear-I/O disables
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gen_en_q <= 1'b0;
        end else if (pair_done || start) begin
            gen_en_q <= 1'b1;
        end else if (clear_io) begin
            gen_en_q <= 1'b0;
        end
    end

    // 16 MHz range tick from fractional accumulator
    logic [7:0] acc_q, acc_sum;
    logic range_tick;
    assign acc_sum = acc_q + RANGE_STEP;
    assign range_tick = acc_sum >= RANGE_MOD;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_q <= 8'h00;
        end else if (range_tick) begin
            acc_q <= acc_sum - RANGE_MOD;
        end else begin
            acc_q <= acc_sum;
        end
    end

    logic [15:0] range_q;
    logic atcrbs_rise;
    assign atcrbs_rise = atcrbs_s && !atcrbs_prev_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            atcrbs_prev_q <= 1'b0;
            range_q <= 16'h0000;
        end else begin
            atcrbs_prev_q <= atcrbs_s;
            if (atcrbs_rise) begin
                range_q <= 16'h0000;
            end else if (range_tick) begin
                range_q <= range_q + 16'h0001;
            end
        end
    end

    // interrogation injector; independent of busy and done
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            interrog_fire <= 1'b0;
            interrog_type <= 4'h0;
        end else begin
            interrog_fire <= gen_en_q && (itype != 4'h0) && range_tick
                             && (range_q == word1_q);
            interrog_type <= itype;
        end
    end

    // reply sampler
    reply_state_e state_q;
    logic [CHIP_CW-1:0] chip_cnt_q;
    logic [7:0] chip_idx_q, chip_total;
    logic first_chip_q, err_q, side_q, amp_have_q;
    logic [63:0] data_q;
    logic [15:0] toa_q, end_q;
    logic [ADC_W-1:0] amp_q;
    logic [15:0] snap1_q, snap2_q;
    logic video_sel, lead_edge, chip_end, chip_mid;

    assign chip_total = dabs_mode ? CHIPS_D : CHIPS_A;
    assign video_sel = (chan == loop_test_pkg::CHAN_DIFF) ? video_s[1] :
                       (chan == loop_test_pkg::CHAN_OMNI) ? video_s[2] :
                       video_s[0];
    assign lead_edge = video_sel && !video_prev_q;
    assign chip_end = chip_cnt_q == CHIP_LAST;
    assign chip_mid = chip_cnt_q == CHIP_MID;
    assign adc_chan = chan;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            video_prev_q <= 1'b0;
        end else begin
            video_prev_q <= video_sel;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_IDLE;
            chip_cnt_q <= '0;
            chip_idx_q <= 8'h00;
        end else if (start) begin
            state_q <= ST_WAIT;
            chip_cnt_q <= '0;
            chip_idx_q <= 8'h00;
        end else if (clear_io) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                ST_WAIT: begin
                    if (lead_edge) begin
                        state_q <= ST_SAMPLE;
                        chip_cnt_q <= '0;
                    end
                end
                ST_SAMPLE: begin
                    chip_cnt_q <= chip_end ? '0 : chip_cnt_q + 1'b1;
                    if (chip_end) begin
                        chip_idx_q <= chip_idx_q + 8'h01;
                        if (chip_idx_q == chip_total - 8'h01) begin
                            state_q <= ST_FINISH;
                        end
                    end
                end
                ST_FINISH: begin
                    if (amp_have_q) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // data bits, ppm check, arrival time, boresight side
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_q <= 64'h0;
            first_chip_q <= 1'b0;
            err_q <= 1'b0;
            side_q <= 1'b0;
            toa_q <= 16'h0000;
            end_q <= 16'h0000;
            snap1_q <= loop_test_pkg::CTRL_RESET;
            snap2_q <= loop_test_pkg::CTRL_RESET;
        end else if (start) begin
            data_q <= 64'h0;
            err_q <= 1'b0;
        end else if (state_q == ST_WAIT && lead_edge) begin
            toa_q <= range_q;
            side_q <= left_s;
            snap1_q <= word1_q;
            snap2_q <= word2_q;
        end else if (state_q == ST_SAMPLE && chip_mid) begin
            if (!dabs_mode) begin
                data_q <= {data_q[62:0], video_sel};
            end else if (!chip_idx_q[0]) begin
                first_chip_q <= video_sel;
            end else begin
                data_q <= {data_q[62:0], first_chip_q};
                if (first_chip_q == video_sel) begin
                    err_q <= 1'b1;
                end
            end
        end else if (state_q == ST_FINISH && amp_have_q) begin
            end_q <= range_q;
        end
    end

    // a/d conversion on detection
    logic adc_rise;
    assign adc_rise = adc_done_s && !adc_prev_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            adc_prev_q <= 1'b0;
            adc_start <= 1'b0;
            amp_have_q <= 1'b0;
            amp_q <= '0;
        end else begin
            adc_prev_q <= adc_done_s;
            adc_start <= !start && state_q == ST_WAIT && lead_edge;
            if (start) begin
                amp_have_q <= 1'b0;
            end else if (adc_rise && state_q != ST_IDLE && state_q != ST_WAIT
                         && !amp_have_q) begin
                amp_q <= adc_data;
                amp_have_q <= 1'b1;
            end
        end
    end

    // busy and done handshake; completion wins over clear-I/O
    logic finish;
    assign finish = state_q == ST_FINISH && amp_have_q && !start;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            busy <= 1'b1;
            done <= 1'b0;
        end else if (finish) begin
            busy <= 1'b0;
            done <= 1'b1;
        end else if (clear_io) begin
            busy <= 1'b0;
            done <= 1'b0;
        end
    end
    assign irq_req = done;

    // result words and read pointer
    function automatic logic [15:0] result_word(input logic [3:0] idx,
            input logic [63:0] d);
        logic [1:0] sel;
        sel = 2'(idx - loop_test_pkg::RES_DATA0);
        result_word = d[(3 - sel) * 16 +: 16];
    endfunction

    logic [3:0] ptr_q;
    logic [15:0] res_word;
    always_comb begin
        res_word = 16'h0000;
        if (ptr_q == loop_test_pkg::RES_TOA) begin
            res_word = toa_q;
        end else if (ptr_q == loop_test_pkg::RES_AMP) begin
            res_word = 16'(amp_q);
        end else if (ptr_q == loop_test_pkg::RES_FLAGS) begin
            res_word[loop_test_pkg::FLAG_SIDE_BIT] = side_q;
            res_word[loop_test_pkg::FLAG_ERR_BIT] = err_q;
        end else if (ptr_q >= loop_test_pkg::RES_DATA0 &&
                     ptr_q <= loop_test_pkg::RES_DATA3) begin
            res_word = result_word(ptr_q, data_q);
        end else if (ptr_q == loop_test_pkg::RES_CTRL1) begin
            res_word = snap1_q;
        end else if (ptr_q == loop_test_pkg::RES_CTRL2) begin
            res_word = snap2_q;
        end else if (ptr_q == loop_test_pkg::RES_COUNT) begin
            res_word = {8'h00, chip_idx_q};
        end else if (ptr_q == loop_test_pkg::RES_END) begin
            res_word = end_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ptr_q <= 4'h0;
        end else if (start) begin
            ptr_q <= 4'h0;
        end else if (result_rd) begin
            ptr_q <= (ptr_q == loop_test_pkg::RES_END) ? 4'h0
                     : ptr_q + 4'h1;
        end
    end

    // apb read data, registered in the setup cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= !mapped(paddr);
            prdata <= 32'h0;
            if (!pwrite) begin
                unique case (paddr)
                    loop_test_pkg::OFS_CTRL: prdata <= {word2_q, word1_q};
                    loop_test_pkg::OFS_STATUS: begin
                        prdata[loop_test_pkg::STAT_BUSY_BIT] <= busy;
                        prdata[loop_test_pkg::STAT_DONE_BIT] <= done;
                        prdata[loop_test_pkg::STAT_PHASE_BIT] <= phase_q;
                        prdata[loop_test_pkg::STAT_GEN_BIT] <= gen_en_q;
                    end
                    loop_test_pkg::OFS_RESULT: prdata <= {16'h0000, res_word};
                    loop_test_pkg::OFS_RANGE: prdata <= {16'h0000, range_q};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule

// >>> testbench/loop_test_props.sv
// checker on the loop-test unit ports: handshake, injector, converter
// assumes the port names and package constants of loop_test_unit
`timescale 1ns/1ps
module loop_test_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // injector, converter, handshake
    input wire logic interrog_fire,
    input wire logic [3:0] interrog_type,
    input wire logic adc_start,
    input wire logic busy,
    input wire logic done,
    input wire logic irq_req
);
    logic acc;
    logic cmd;
    logic go;
    logic stop;
    logic known;
    assign acc = psel && penable && pready;
    assign cmd = acc && pwrite && paddr == loop_test_pkg::OFS_CMD;
    assign go = cmd && pwdata[loop_test_pkg::CMD_START_BIT];
    assign stop = cmd && pwdata[loop_test_pkg::CMD_CLEAR_BIT];
    assign known = paddr inside {loop_test_pkg::OFS_CTRL,
        loop_test_pkg::OFS_CMD, loop_test_pkg::OFS_STATUS,
        loop_test_pkg::OFS_RESULT, loop_test_pkg::OFS_RANGE};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    start_arms_a: assert property (go |=> busy && !done)
        else $error("start did not arm the sampler");
    end_flags_a: assert property (done |-> !busy && irq_req)
        else $error("done without idle busy and request");
    done_cause_a: assert property ($rose(done) |-> $past(busy))
        else $error("done rose without a capture");
    busy_exit_a: assert property ($fell(busy) |-> done || $past(stop))
        else $error("busy dropped without completion");
    fire_type_a: assert property (interrog_fire |-> interrog_type != 4'h0)
        else $error("fire with type zero");
    fire_pulse_a: assert property (interrog_fire |=> !interrog_fire)
        else $error("fire longer than one cycle");
    fire_quiet_a: assert property (interrog_fire && !busy && !$past(busy)
        |-> $stable(done) || $past(stop))
        else $error("injection touched done");
    adc_once_a: assert property (adc_start |-> busy ##1 !adc_start [*4])
        else $error("converter start outside one capture");
    map_err_a: assert property (acc |-> pslverr == !known)
        else $error("slave error mismatch");
endmodule
bind loop_test_unit loop_test_props u_props (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .interrog_fire(interrog_fire),
    .interrog_type(interrog_type), .adc_start(adc_start), .busy(busy),
    .done(done), .irq_req(irq_req)
);

// >>> testbench/reply_source.sv
// behavioural reply video and converter source for the bench
// assumes chips msb first, CHIP clocks each, one reply at a time
`timescale 1ns/1ps
module reply_source #(
    parameter int ADC_W = 10,
    parameter int CHIP = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // reply request
    input wire logic go,
    input wire logic [1:0] chan,
    input wire logic [7:0] chips,
    input wire logic [3:0] nch,
    input wire logic [ADC_W-1:0] amp,
    input wire logic [4:0] lag,
    // video and converter pins
    input wire logic adc_start,
    input wire logic [1:0] adc_chan,
    output logic [2:0] if_pulse,
    output logic adc_done,
    output logic [ADC_W-1:0] adc_data
);
    logic [7:0] sh_q;
    logic [3:0] left_q;
    int tick_q;
    int cnt_q;
    // a new request is ignored while a reply is on the air
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            left_q <= 4'h0;
            tick_q <= 0;
        end else if (go && left_q == 4'h0) begin
            sh_q <= chips;
            left_q <= nch;
            tick_q <= 0;
        end else if (left_q != 4'h0) begin
            tick_q <= (tick_q == CHIP - 1) ? 0 : tick_q + 1;
            if (tick_q == CHIP - 1) begin
                sh_q <= {sh_q[6:0], 1'b0};
                left_q <= left_q - 4'h1;
            end
        end
    end
    always_comb begin
        if_pulse = 3'h0;
        if (left_q != 4'h0) if_pulse[chan] = sh_q[7];
    end
    // converter: data settles, done held three cycles, then data garbled
    always_ff @(posedge clk_sys) begin
        if (rst) cnt_q <= 0;
        else if (adc_start) cnt_q <= int'(lag) + 4;
        else if (cnt_q > 0) cnt_q <= cnt_q - 1;
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            adc_done <= 1'b0;
            adc_data <= '0;
        end else begin
            adc_done <= cnt_q >= 1 && cnt_q <= 3;
            if (cnt_q == 4) adc_data <= amp + ADC_W'(adc_chan);
            else if (adc_done && cnt_q == 0) adc_data <= ~adc_data;
        end
    end
endmodule

// >>> testbench/loop_test_unit_tb.sv
// bench: control pairs, injector timing, reply captures over apb
// assumes reply_source stands in for the video and converter side
`timescale 1ns/1ps
module loop_test_unit_tb;
    logic clk_sys, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, chips = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0001228f;
    logic boresight_left = 1'b0, atcrbs_interrog = 1'b0, go = 1'b0;
    logic [1:0] adc_chan, chan = 2'h0;
    logic [9:0] adc_data, amp = 10'h000;
    logic [3:0] interrog_type, nch = 4'h0;
    logic [4:0] lag = 5'h00;
    logic [2:0] if_pulse;
    logic pready, pslverr, adc_start, adc_done, err;
    logic interrog_fire, busy, done, irq_req;
    logic [31:0] res [12];
    int fails = 0, tests_run = 0;
    loop_test_unit #(.CHIP_CYCLES(8), .ATCRBS_BITS(4), .DABS_BITS(4)) u_dut (
        .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .if_pulse, .boresight_left, .atcrbs_interrog,
        .adc_start, .adc_chan, .adc_done, .adc_data, .interrog_fire,
        .interrog_type, .busy, .done, .irq_req);
    reply_source #(.ADC_W(10), .CHIP(8)) u_src (.clk_sys, .rst, .go, .chan,
        .chips, .nch, .amp, .lag, .adc_start, .adc_chan, .if_pulse,
        .adc_done, .adc_data);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // ppm chips: each bit then its complement; bad repeats the last chip
    function automatic logic [7:0] chips_of(input logic m,
        input logic [3:0] b, input logic bad);
        if (!m) return {b, 4'h0};
        return {b[3], ~b[3], b[2], ~b[2], b[1], ~b[1], b[0], ~b[0] ^ bad};
    endfunction
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic give_up;
        fails++;
        give_verdict();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) give_up();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic pair(input logic [15:0] w1, input logic [15:0] w2);
        apb(1'b1, loop_test_pkg::OFS_CTRL, {16'h0, w1});
        apb(1'b1, loop_test_pkg::OFS_CTRL, {16'h0, w2});
    endtask
    initial begin
        logic [15:0] w1, w2;
        logic [3:0] t, bits;
        logic [1:0] c;
        logic m, bad;
        int n, nr;
        time t0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        apb(1'b0, loop_test_pkg::OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check(32'(err), 32'h1);
        apb(1'b1, loop_test_pkg::OFS_CTRL, 32'h1234);
        apb(1'b0, loop_test_pkg::OFS_STATUS, 32'h0);
        check(rd & 32'h4, 32'h4);
        apb(1'b0, loop_test_pkg::OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, loop_test_pkg::OFS_CTRL, 32'h45);
        apb(1'b0, loop_test_pkg::OFS_CTRL, 32'h0);
        check(rd, 32'h0045_1234);
        for (int g = 0; g < 3; g++) begin
            seed = step(seed);
            t = (g == 1) ? 4'h0 : 4'h1 + 4'(seed % 15);
            atcrbs_interrog <= 1'b1;
            t0 = $time;
            pair(16'h0080, {12'h0, t});
            atcrbs_interrog <= 1'b0;
            if (g == 2) apb(1'b1, loop_test_pkg::OFS_CMD, 32'h2);
            for (n = 0; n < 1000 && interrog_fire !== 1'b1; n++)
                @(posedge clk_sys);
            n = int'(($time - t0) / 10);
            if (g == 0) begin
                check(32'(n >= 795 && n <= 815), 32'h1);
                check(32'(interrog_type), 32'(t));
                check(32'({busy, done, irq_req}), 32'h0);
                apb(1'b0, loop_test_pkg::OFS_RANGE, 32'h0);
                check(rd, 32'h0000_0081);
            end else begin
                check(32'(interrog_fire), 32'h0);
            end
        end
        for (int k = 0; k < 6; k++) begin
            seed = step(seed);
            m = k[1] ? seed[0] : k[0];
            c = (k < 3) ? 2'(k) : 2'(seed[2:1] % 3);
            bits = {1'b1, seed[5:3]};
            bad = m & k[0] & !k[2];
            w1 = seed[31:16];
            w2 = {9'h0, m, c, 4'h0};
            chan <= c;
            amp <= seed[16:7];
            lag <= {seed[17], 4'h0};
            boresight_left <= seed[18];
            chips <= chips_of(m, bits, bad);
            nch <= m ? 4'h8 : 4'h4;
            pair(w1, w2);
            apb(1'b1, loop_test_pkg::OFS_CMD, 32'h1);
            check(32'({busy, done}), 32'h2);
            apb(1'b0, loop_test_pkg::OFS_STATUS, 32'h0);
            check(rd & 32'hf, 32'h9);
            go <= 1'b1;
            @(posedge clk_sys);
            go <= 1'b0;
            for (n = 0; n < 400 && done !== 1'b1; n++) @(posedge clk_sys);
            if (done !== 1'b1) give_up();
            check(32'({busy, irq_req}), 32'h1);
            nr = (k == 2) ? 2 : 12;
            for (int i = 0; i < nr; i++) begin
                apb(1'b0, loop_test_pkg::OFS_RESULT, 32'h0);
                res[i] = {16'h0, rd[15:0]};
            end
            check(res[1], 32'(seed[16:7] + 10'(c)));
            if (nr == 12) begin
                check(res[2] & 32'h3, 32'({bad, seed[18]}));
                check(res[6] & 32'hf, 32'(bits));
                check(res[7], 32'(w1));
                check(res[8], 32'(w2));
                check(res[9], m ? 32'h8 : 32'h4);
                check(res[11], res[0]);
            end
        end
        give_verdict();
    end
endmodule
